// ---- design/tws_defs.svh ----
// Purpose: constants of the three-wire serial port
// Assumes: byte-wide processor register port
// Notes: offsets are byte addresses of the register port
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
// register addresses
`define TWS_ADDR_MODE 16'hff80
`define TWS_ADDR_CSEL 16'hff81
`define TWS_ADDR_TXB 16'hff82
`define TWS_ADDR_SHR 16'hff83
// mode register field positions
`define TWS_BIT_EN 7
`define TWS_BIT_TRMD 6
`define TWS_BIT_DIR 4
`define TWS_BIT_BUSY 0
// clock select register field span
`define TWS_BIT_CKP 4
// reset value of every register
`define TWS_RST_BYTE 8'h00
// clock select code for an external serial clock
`define TWS_CKS_EXT 3'h7
// index of the last of sixteen serial clock edges
`define TWS_LAST_EDGE 4'hf
`endif

// ---- design/tws_pkg.sv ----
// Purpose: types of the three-wire serial port
// Assumes: constants live in tws_defs.svh
// Notes: state structs hold every flop of each clock domain except the two link reset synchroniser flops
package tws_pkg;
    // serial engine state
    typedef enum logic {TWS_IDLE, TWS_RUN} tws_state_t;
    // mode register fields
    typedef struct packed {logic en; logic trmd; logic dir;} tws_mode_t;
    // clock select register fields
    typedef struct packed {logic ckp; logic dap; logic [2:0] cks;} tws_csel_t;
    // configuration seen by the link side
    typedef struct packed {tws_mode_t mode; tws_csel_t csel;} tws_cfg_t;
    // processor register access
    typedef struct packed {logic [15:0] addr; logic wr; logic rd; logic [7:0] wdata;} tws_req_t;
    // register-side state
    typedef struct packed {
        tws_mode_t mode;
        tws_csel_t csel;
        logic [7:0] txbuf;
        logic [7:0] shreg;
        logic busy;
        logic req_tgl;
        logic done_s1;
        logic done_s2;
        logic done_seen;
        logic [7:0] rdata;
        logic done_pulse;
    } tws_sys_t;
    // link-side state
    typedef struct packed {
        tws_state_t state;
        tws_cfg_t cfg_s1;
        tws_cfg_t cfg_s2;
        logic req_s1;
        logic req_s2;
        logic req_seen;
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic si_s1;
        logic si_s2;
        logic [3:0] cnt;
        logic [6:0] div;
        logic [7:0] sh;
        logic so;
        logic sck;
        logic [7:0] rxhold;
        logic done_tgl;
    } tws_link_t;
endpackage

// ---- design/tws_top.sv ----
// Purpose: three-wire clocked serial port, one byte per transfer
// Assumes: registers on CLK_SYS_I, serial engine on CLK_LINK_I
// Notes: config and buffers stay stable while busy, so they cross as levels
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_top (
    // register clock, reset and freeze
    input wire logic CLK_SYS_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    // serial engine clock
    input wire logic CLK_LINK_I,
    // processor register port
    input wire tws_pkg::tws_req_t REG_REQ_I,
    output logic [7:0] REG_RDATA_O,
    output logic TRANSFER_DONE_IRQ_O,
    // serial pins
    input wire logic SERIAL_CLOCK_PIN_I,
    output logic SERIAL_CLOCK_PIN_O,
    output logic SERIAL_CLOCK_PIN_OE_O,
    input wire logic SERIAL_DATA_IN_PIN_I,
    output logic SERIAL_DATA_OUT_PIN_O
);
    import tws_pkg::*;

    tws_sys_t s_reg; // register-side state
    tws_sys_t s_next;
    tws_link_t l_reg; // link-side state
    tws_link_t l_next;
    logic sys_start; // transfer request this cycle
    logic rst_l_s1; // reset synchroniser, link side
    logic rst_l_n;
    logic master; // internal clock selected
    logic [6:0] lim; // half period minus one
    logic tick; // serial clock edge now
    logic sample; // this edge samples input

    // next output bit for the chosen order
    function automatic logic out_bit(input logic [7:0] v, input logic lsb);
        out_bit = lsb ? v[0] : v[7];
    endfunction

    // register side
    always_comb
    begin
        s_next = s_reg;
        s_next.done_pulse = 1'b0;
        // done toggle crosses by two flops
        s_next.done_s1 = l_reg.done_tgl;
        s_next.done_s2 = s_reg.done_s1;
        sys_start = 1'b0;
        if (REG_REQ_I.wr)
        begin
            unique case (REG_REQ_I.addr)
                `TWS_ADDR_MODE:
                begin
                    // busy and bit 5 ignore writes
                    s_next.mode.en = REG_REQ_I.wdata[`TWS_BIT_EN];
                    s_next.mode.trmd = REG_REQ_I.wdata[`TWS_BIT_TRMD];
                    s_next.mode.dir = REG_REQ_I.wdata[`TWS_BIT_DIR];
                end
                `TWS_ADDR_CSEL:
                begin
                    s_next.csel = REG_REQ_I.wdata[`TWS_BIT_CKP:0];
                end
                `TWS_ADDR_TXB:
                begin
                    s_next.txbuf = REG_REQ_I.wdata;
                    // a write during a transfer is not a new start
                    if (s_reg.mode.en && s_reg.mode.trmd && !s_reg.busy)
                    begin
                        sys_start = 1'b1;
                    end
                end
                default:
                begin
                    // shift register and unmapped: no write effect
                end
            endcase
        end
        if (REG_REQ_I.rd)
        begin
            unique case (REG_REQ_I.addr)
                `TWS_ADDR_MODE:
                begin
                    s_next.rdata = {s_reg.mode.en, s_reg.mode.trmd, 1'b0,
                                    s_reg.mode.dir, 3'h0, s_reg.busy};
                end
                `TWS_ADDR_CSEL:
                begin
                    s_next.rdata = {3'h0, s_reg.csel};
                end
                `TWS_ADDR_TXB:
                begin
                    s_next.rdata = s_reg.txbuf;
                end
                `TWS_ADDR_SHR:
                begin
                    s_next.rdata = s_reg.shreg;
                    if (s_reg.mode.en && !s_reg.mode.trmd && !s_reg.busy)
                    begin
                        sys_start = 1'b1;
                    end
                end
                default:
                begin
                    s_next.rdata = `TWS_RST_BYTE;
                end
            endcase
        end
        // end of transfer: capture received byte
        if (s_reg.done_s2 != s_reg.done_seen)
        begin
            s_next.done_seen = s_reg.done_s2;
            if (s_reg.busy)
            begin
                s_next.busy = 1'b0;
                s_next.shreg = l_reg.rxhold;
                s_next.done_pulse = 1'b1;
            end
        end
        if (sys_start)
        begin
            s_next.busy = 1'b1;
            s_next.req_tgl = ~s_reg.req_tgl;
        end
        // disable clears busy and shift register
        if (!s_next.mode.en)
        begin
            s_next.busy = 1'b0;
            s_next.shreg = `TWS_RST_BYTE;
        end
        if (!CE_I)
        begin
            s_next = s_reg;
        end
    end

    // register-side flops; every field resets to zero
    always_ff @(posedge CLK_SYS_I)
    begin
        if (!RST_N_I)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // reset brought into the link domain by two flops
    always_ff @(posedge CLK_LINK_I)
    begin
        rst_l_s1 <= RST_N_I;
        rst_l_n <= rst_l_s1;
    end

    // clock source and edge decode
    always_comb
    begin
        master = (l_reg.cfg_s2.csel.cks != `TWS_CKS_EXT);
        lim = 7'((8'h01 << l_reg.cfg_s2.csel.cks) - 8'h01);
        tick = master ? (l_reg.div == lim) : (l_reg.sck_s2 != l_reg.sck_d);
        sample = l_reg.cnt[0] ^ l_reg.cfg_s2.csel.dap;
    end

    // serial engine
    always_comb
    begin
        l_next = l_reg;
        // config and pins are level-synchronised
        l_next.cfg_s1 = {s_reg.mode, s_reg.csel};
        l_next.cfg_s2 = l_reg.cfg_s1;
        l_next.req_s1 = s_reg.req_tgl;
        l_next.req_s2 = l_reg.req_s1;
        l_next.sck_s1 = SERIAL_CLOCK_PIN_I;
        l_next.sck_s2 = l_reg.sck_s1;
        l_next.sck_d = l_reg.sck_s2;
        l_next.si_s1 = SERIAL_DATA_IN_PIN_I;
        l_next.si_s2 = l_reg.si_s1;
        unique case (l_reg.state)
            TWS_IDLE:
            begin
                // idle clock level set by polarity
                l_next.sck = ~l_reg.cfg_s2.csel.ckp;
                l_next.div = 7'h00;
                if (l_reg.req_s2 != l_reg.req_seen)
                begin
                    l_next.req_seen = l_reg.req_s2;
                    l_next.sh = s_reg.txbuf;
                    l_next.so = out_bit(s_reg.txbuf, l_reg.cfg_s2.mode.dir);
                    l_next.cnt = 4'h0;
                    l_next.state = TWS_RUN;
                end
            end
            TWS_RUN:
            begin
                if (tick)
                begin
                    l_next.div = 7'h00;
                    if (master)
                    begin
                        l_next.sck = ~l_reg.sck;
                    end
                    if (sample)
                    begin
                        // shift in at the end opposite the output
                        l_next.sh = l_reg.cfg_s2.mode.dir ?
                                    {l_reg.si_s2, l_reg.sh[7:1]} :
                                    {l_reg.sh[6:0], l_reg.si_s2};
                    end
                    else
                    begin
                        l_next.so = out_bit(l_reg.sh, l_reg.cfg_s2.mode.dir);
                    end
                    if (l_reg.cnt == `TWS_LAST_EDGE)
                    begin
                        // eighth clock done
                        l_next.state = TWS_IDLE;
                        l_next.rxhold = l_next.sh;
                        l_next.done_tgl = ~l_reg.done_tgl;
                    end
                    else
                    begin
                        l_next.cnt = l_reg.cnt + 4'h1;
                    end
                end
                else if (master)
                begin
                    l_next.div = l_reg.div + 7'h01;
                end
            end
        endcase
        // disabled: drop any request and abort
        if (!l_reg.cfg_s2.mode.en)
        begin
            l_next.state = TWS_IDLE;
            l_next.req_seen = l_reg.req_s2;
            l_next.sh = `TWS_RST_BYTE;
            l_next.cnt = 4'h0;
        end
        // data output low when disabled or in receive mode
        if (!l_reg.cfg_s2.mode.en || !l_reg.cfg_s2.mode.trmd)
        begin
            l_next.so = 1'b0;
        end
    end

    // link-side flops
    always_ff @(posedge CLK_LINK_I)
    begin
        if (!rst_l_n)
        begin
            l_reg <= '0;
        end
        else
        begin
            l_reg <= l_next;
        end
    end

    // outputs
    assign REG_RDATA_O = s_reg.rdata;
    assign TRANSFER_DONE_IRQ_O = s_reg.done_pulse;
    assign SERIAL_CLOCK_PIN_O = l_reg.sck;
    assign SERIAL_CLOCK_PIN_OE_O = l_reg.cfg_s2.mode.en && master;
    assign SERIAL_DATA_OUT_PIN_O = l_reg.so;

    // checks on the register side
    tx_start_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && REG_REQ_I.wr && REG_REQ_I.addr == `TWS_ADDR_TXB && s_reg.mode.en &&
        s_reg.mode.trmd && !s_reg.busy |=> s_reg.busy && $changed(s_reg.req_tgl))
        else $error("buffer write did not start a transfer");
    rx_start_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && REG_REQ_I.rd && REG_REQ_I.addr == `TWS_ADDR_SHR && s_reg.mode.en &&
        !s_reg.mode.trmd && !s_reg.busy |=> s_reg.busy)
        else $error("shift register read did not start reception");
    disable_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        !s_reg.mode.en |-> !s_reg.busy && s_reg.shreg == 8'h00)
        else $error("disabled port kept busy or data");
    mode_read_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        CE_I && REG_REQ_I.rd && REG_REQ_I.addr == `TWS_ADDR_MODE |=>
        REG_RDATA_O[`TWS_BIT_BUSY] == $past(s_reg.busy) && REG_RDATA_O[5] == 1'b0)
        else $error("mode read shows wrong busy or bit 5");
    // a low clock enable holds the pulse, so only its first cycle is tied to busy
    done_irq_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TRANSFER_DONE_IRQ_O && !$past(TRANSFER_DONE_IRQ_O) |->
        !s_reg.busy && $past(s_reg.busy) ##1 (!TRANSFER_DONE_IRQ_O || !$past(CE_I)))
        else $error("done pulse not tied to busy clearing");
    reset_zero_a: assert property (@(posedge CLK_SYS_I)
        !RST_N_I |=> s_reg.txbuf == 8'h00 && s_reg.shreg == 8'h00 && s_reg.csel == 5'h00)
        else $error("registers not cleared by reset");

    // checks on the link side
    so_low_a: assert property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        !l_reg.cfg_s2.mode.trmd |=> !SERIAL_DATA_OUT_PIN_O)
        else $error("data output not low in receive mode");
    stop_idle_a: assert property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        !l_reg.cfg_s2.mode.en |=> l_reg.state == TWS_IDLE)
        else $error("engine ran while disabled");
    edge_count_a: assert property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        $changed(l_reg.done_tgl) |-> $past(l_reg.cnt) == `TWS_LAST_EDGE)
        else $error("transfer ended before sixteen edges");
    divider_a: assert property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        l_reg.state == TWS_RUN && master && $past(l_reg.state) == TWS_RUN &&
        $changed(l_reg.sck) |-> $past(l_reg.div) == $past(lim))
        else $error("serial clock edge off the divider");
    msb_first_a: assert property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        l_reg.state == TWS_RUN && tick && !sample && l_reg.cfg_s2.mode.en &&
        l_reg.cfg_s2.mode.trmd && !l_reg.cfg_s2.mode.dir |=> l_reg.so == $past(l_reg.sh[7]))
        else $error("wrong bit presented in msb order");

    // main scenarios
    tx_done_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TRANSFER_DONE_IRQ_O && s_reg.mode.trmd);
    rx_done_c: cover property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
        TRANSFER_DONE_IRQ_O && !s_reg.mode.trmd);
    lsb_run_c: cover property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        $changed(l_reg.done_tgl) && l_reg.cfg_s2.mode.dir);
    slave_run_c: cover property (@(posedge CLK_LINK_I) disable iff (!rst_l_n)
        $changed(l_reg.done_tgl) && !master);
endmodule

// ---- verif/three_wire_serial_port_tb_top.sv ----
// Purpose: self-checking bench of the three-wire serial port
// Assumes: register strobes driven 1 ns after the system clock edge
// Notes: slave clock mode is only checked for its output enable
`timescale 1ns/1ps
`include "tws_defs.svh"
module three_wire_serial_port_tb_top;
    import tws_pkg::*;
    typedef struct packed {logic [7:0] mode, csel, tx, peer, shr, prx;} tws_row_t;
    logic clk = 1'b0;
    logic clk_link = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic ext_sck = 1'b1; // idle external clock, slave frames not driven
    logic load = 1'b0;
    logic [7:0] pbyte = 8'h00;
    tws_req_t req = '0;
    logic [7:0] rdata, prx, v;
    logic irq, sck_o, sck_oe, si, so;
    logic [3:0] n_rise;
    wire sck = sck_oe ? sck_o : ext_sck; // pin level from both drivers
    int n_mismatch = 0;
    int n_compared = 0;
    int irq_cnt = 0;
    int c0;
    // ordinary transfers: lsb rows expect the peer bytes reversed
    tws_row_t rows [6] = '{
        '{8'hc0, 8'h02, 8'ha5, 8'h3c, 8'h3c, 8'ha5},
        '{8'hd0, 8'h02, 8'h01, 8'h80, 8'h01, 8'h80},
        '{8'hc0, 8'h01, 8'hff, 8'h00, 8'h00, 8'hff},
        '{8'h80, 8'h02, 8'h00, 8'hc3, 8'hc3, 8'h00},
        '{8'h90, 8'h02, 8'h00, 8'h0f, 8'hf0, 8'h00},
        '{8'hd0, 8'h06, 8'h6e, 8'h2b, 8'hd4, 8'h76}};
    tws_top i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .CLK_LINK_I(clk_link),
        .REG_REQ_I(req), .REG_RDATA_O(rdata), .TRANSFER_DONE_IRQ_O(irq),
        .SERIAL_CLOCK_PIN_I(ext_sck), .SERIAL_CLOCK_PIN_O(sck_o),
        .SERIAL_CLOCK_PIN_OE_O(sck_oe), .SERIAL_DATA_IN_PIN_I(si),
        .SERIAL_DATA_OUT_PIN_O(so));
    tws_peer_model i_peer (.sck_i(sck), .so_i(so), .si_o(si), .load_i(load),
        .byte_i(pbyte), .rx_o(prx), .n_rise_o(n_rise));
    // system clock, 100 MHz
    always #5 clk = ~clk;
    // link clock, 6 ns period, odd start offset so phases drift apart
    initial
    begin
        #1.3;
        forever #3 clk_link = ~clk_link;
    end
    // done pulses last one cycle; count them mid-cycle, where they are settled
    always @(negedge clk)
    begin
        if (irq === 1'b1)
            irq_cnt++;
    end
    task automatic close_out();
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        step(1);
        req.wr = 1'b0;
        // let an edge pass so a following write never re-raises the strobe at once
        step(1);
    endtask
    // read data is taken one edge after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        req.addr = a;
        req.rd = 1'b1;
        step(1);
        req.rd = 1'b0;
        step(1);
        d = rdata;
    endtask
    task automatic wait_idle();
        logic [7:0] m;
        repeat (1000)
        begin
            rd(`TWS_ADDR_MODE, m);
            if (m[0] === 1'b0)
                return;
        end
        n_mismatch++;
        close_out();
    endtask
    // config only while disabled, start by buffer write or shift read
    task automatic run(input tws_row_t r);
        wr(`TWS_ADDR_MODE, 8'h00);
        wr(`TWS_ADDR_CSEL, r.csel);
        wr(`TWS_ADDR_MODE, r.mode);
        pbyte = r.peer;
        load = 1'b1;
        c0 = irq_cnt;
        if (r.mode[6])
            wr(`TWS_ADDR_TXB, r.tx);
        else
            rd(`TWS_ADDR_SHR, v);
        rd(`TWS_ADDR_MODE, v);
        chk("busy flag", 8'h01, {7'h0, v[0]});
        wait_idle();
        load = 1'b0;
        rd(`TWS_ADDR_SHR, v);
        chk("shift register", r.shr, v);
        chk("peer byte", r.prx, prx);
        chk("rising edges", 8'h08, {4'h0, n_rise});
        chk("done pulses", 8'h01, 8'(irq_cnt - c0));
        // in receive-only mode that shift read has already started the next reception
        rd(`TWS_ADDR_MODE, v);
        chk("mode register", {r.mode[7:1], ~r.mode[6]}, v);
    endtask
    // main sequence: table rows, then reset and awkward cases
    initial
    begin
        step(12);
        rst_n = 1'b1;
        foreach (rows[i])
            run(rows[i]);
        // second reset with the port idle after the last transmit row
        rst_n = 1'b0;
        step(12);
        rst_n = 1'b1;
        for (int a = 0; a < 4; a++)
        begin
            rd(`TWS_ADDR_MODE + 16'(a), v);
            chk("reset value", `TWS_RST_BYTE, v);
        end
        chk("data out stopped", 8'h00, {7'h0, so});
        chk("clock enable stopped", 8'h00, {7'h0, sck_oe});
        rd(16'hff84, v);
        chk("unmapped read", 8'h00, v);
        wr(`TWS_ADDR_TXB, 8'h5a);
        wr(`TWS_ADDR_SHR, 8'h77);
        rd(`TWS_ADDR_SHR, v);
        chk("shift register write", 8'h00, v);
        wr(`TWS_ADDR_MODE, 8'h81);
        rd(`TWS_ADDR_MODE, v);
        chk("busy read only", 8'h80, v);
        ce = 1'b0;
        wr(`TWS_ADDR_TXB, 8'h11);
        ce = 1'b1; // resumed with no done pending
        rd(`TWS_ADDR_TXB, v);
        chk("buffer readback", 8'h5a, v);
        // idle clock level follows polarity; external select releases the pin
        wr(`TWS_ADDR_MODE, 8'h00);
        wr(`TWS_ADDR_CSEL, 8'h10);
        wr(`TWS_ADDR_MODE, 8'h80);
        step(4);
        chk("idle clock", 8'h02, {6'h0, sck_oe, sck_o});
        wr(`TWS_ADDR_MODE, 8'h00); // pins handed back to general use
        wr(`TWS_ADDR_CSEL, {5'h0, `TWS_CKS_EXT});
        wr(`TWS_ADDR_MODE, 8'h80);
        step(4);
        chk("external clock enable", 8'h00, {7'h0, sck_oe});
        // abort in mid-transfer: no done, busy and shift register cleared
        wr(`TWS_ADDR_MODE, 8'h00);
        wr(`TWS_ADDR_CSEL, 8'h02);
        wr(`TWS_ADDR_MODE, 8'hc0);
        pbyte = 8'hff;
        load = 1'b1;
        c0 = irq_cnt;
        wr(`TWS_ADDR_TXB, 8'hf0);
        step(15);
        wr(`TWS_ADDR_MODE, 8'h00);
        rd(`TWS_ADDR_MODE, v);
        chk("abort busy", 8'h00, v);
        rd(`TWS_ADDR_SHR, v);
        chk("abort shift register", 8'h00, v);
        step(60);
        load = 1'b0;
        chk("abort done pulses", 8'h00, 8'(irq_cnt - c0));
        close_out();
    end
endmodule

// ---- verif/tws_peer_model.sv ----
// Purpose: serial peripheral on the far side of the three-wire port
// Assumes: clock type 1, idle high, data sampled on rising serial clock edges
// Notes: sends and collects bytes msb first; the bench reorders for lsb mode
`timescale 1ns/1ps
module tws_peer_model (
    // serial pins
    input wire logic sck_i,
    input wire logic so_i,
    output logic si_o,
    // frame control from the bench
    input wire logic load_i,
    input wire logic [7:0] byte_i,
    output logic [7:0] rx_o,
    output logic [3:0] n_rise_o
);
    logic [7:0] sh; // outgoing bits, msb on the line
    initial
    begin
        sh = 8'h00;
        si_o = 1'b0;
        rx_o = 8'h00;
        n_rise_o = 4'h0;
    end
    // a new frame puts its first bit out before any clock edge
    always @(posedge load_i)
    begin
        sh = byte_i;
        rx_o = 8'h00;
        n_rise_o = 4'h0;
        si_o = byte_i[7];
    end
    // sample on rising edge, then move on; the port's input sync hides the change
    always @(posedge sck_i)
    begin
        if (load_i)
        begin
            rx_o = {rx_o[6:0], so_i};
            sh = {sh[6:0], ~sh[0]};
            si_o = sh[7];
            n_rise_o = n_rise_o + 4'h1;
        end
    end
    // outside frames the line must not keep a value the port could trust
    always @(negedge load_i)
    begin
        si_o = ~si_o;
    end
endmodule
